// file: hdl/bit_logic_regs.svh
// Constants for the bit, logic and call execute block.
`ifndef BIT_LOGIC_REGS_SVH
`define BIT_LOGIC_REGS_SVH
`define REG_ADDR_MAX 6'h3F
`define BIT_POS_MAX 3'h7
`define PC_RESET 11'h000
`define SP_RESET 3'h0
`define WREG_RESET 8'h00
`define PCHB_RESET 3'h0
`define REG_WADDR_RESET 6'h00
`define REG_WDATA_RESET 8'h00
`define ZERO_FLAG_RESET 1'b0
`define CALL_CYCLES 2
`define SKIP_CYCLES 2
`endif

// file: hdl/bit_logic_pkg.sv
// Types shared by the bit, logic and call execute block.
package bit_logic_pkg;
   // Operation codes presented on the decoded-operation port.
   typedef enum logic [2:0] {
      op_none = 3'b000,
      bit_clear_op = 3'b001,
      bit_set_op = 3'b010,
      test_skip_if_zero_op = 3'b011,
      and_immediate_op = 3'b100,
      call_op = 3'b101,
      pch_write_op = 3'b110
   } op_e;
   // Execute sequencer states.
   typedef enum logic [1:0] {
      st_exec = 2'b00,
      st_flush = 2'b01
   } exec_state_e;
endpackage

// file: hdl/bit_modify.sv
// Single-bit modify unit: clears or sets one selected bit of a byte.
`timescale 1ns/1ps
module bit_modify #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] data_in,
   input wire logic [$clog2(WIDTH)-1:0] bit_sel,
   input wire logic set_bit,
   output logic [WIDTH-1:0] data_out,
   output logic bit_value
);
   initial begin
      if (WIDTH < 2) begin
         $error("bit_modify needs WIDTH of at least 2");
      end
   end
   // Build a one-hot mask, then force only that bit; others pass through.
   always_comb begin
      logic [WIDTH-1:0] mask;
      mask = '0;
      mask[bit_sel] = 1'b1;
      data_out = set_bit ? (data_in | mask) : (data_in & ~mask);
      bit_value = data_in[bit_sel];
   end
endmodule // bit_modify

// file: hdl/bit_logic_call_exec.sv
// Execute stage for bit clear/set, bit test-and-skip, immediate AND and call.
`timescale 1ns/1ps
`include "bit_logic_regs.svh"
module bit_logic_call_exec
   import bit_logic_pkg::*;
#(
   parameter int PC_WIDTH = 11,
   parameter int STACK_DEPTH = 8,
   parameter int SP_WIDTH = 3
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire logic [2:0] op_code,
   input wire logic [5:0] reg_addr,
   input wire logic [2:0] bit_pos,
   input wire logic [7:0] imm_data,
   input wire logic [7:0] reg_rdata,
   output logic [5:0] reg_waddr_q,
   output logic [7:0] reg_wdata_q,
   output logic reg_we_q,
   output logic [7:0] working_register_q,
   output logic zero_flag_q,
   output logic [PC_WIDTH-1:0] pc_q,
   output logic [SP_WIDTH-1:0] sp_q,
   output logic [PC_WIDTH-1:0] stack_top_q,
   output logic stack_we_q,
   output logic [2:0] pc_high_buffer_q,
   output logic flush_q,
   output logic busy_q
);
   initial begin
      if (PC_WIDTH != 11 || STACK_DEPTH != (1 << SP_WIDTH)) begin
         $error("bit_logic_call_exec needs PC_WIDTH 11 and STACK_DEPTH 2**SP_WIDTH");
      end
   end

   // Return stack storage, addressed by the stack pointer.
   logic [PC_WIDTH-1:0] stack_q [STACK_DEPTH];
   logic [PC_WIDTH-1:0] stack_d [STACK_DEPTH];
   // Next values of every register.
   logic [5:0] reg_waddr_d;
   logic [7:0] reg_wdata_d;
   logic reg_we_d;
   logic [7:0] working_register_d;
   logic zero_flag_d;
   logic [PC_WIDTH-1:0] pc_d;
   logic [SP_WIDTH-1:0] sp_d;
   logic [PC_WIDTH-1:0] stack_top_d;
   logic stack_we_d;
   logic [2:0] pc_high_buffer_d;
   logic flush_d;
   logic busy_d;
   exec_state_e state_q;
   exec_state_e state_d;
   // Bit modify unit results, the AND result and the decoded operation.
   logic [7:0] modified;
   logic tested_bit;
   logic [7:0] and_result;
   op_e op;

   assign op = op_e'(op_code);
   assign and_result = working_register_q & imm_data;

   // The 6-bit address and 3-bit position fields cover exactly 0..63 and 0..7.
   bit_modify #(.WIDTH(8)) u_bit_modify (
      .data_in(reg_rdata),
      .bit_sel(bit_pos),
      .set_bit(op == bit_set_op),
      .data_out(modified),
      .bit_value(tested_bit)
   );

   // Next-state logic for the whole execute stage.
   always_comb begin
      reg_waddr_d = reg_waddr_q;
      reg_wdata_d = reg_wdata_q;
      reg_we_d = 1'b0;
      working_register_d = working_register_q;
      zero_flag_d = zero_flag_q;
      pc_d = pc_q;
      sp_d = sp_q;
      stack_top_d = stack_top_q;
      stack_we_d = 1'b0;
      pc_high_buffer_d = pc_high_buffer_q;
      flush_d = 1'b0;
      busy_d = 1'b0;
      state_d = state_q;
      for (int i = 0; i < STACK_DEPTH; i++) begin
         stack_d[i] = stack_q[i];
      end
      case (state_q)
         st_exec: begin
            if (instr_valid) begin
               // Ordinary instructions advance the counter by one.
               pc_d = pc_q + PC_WIDTH'(1);
               case (op)
                  bit_clear_op, bit_set_op: begin
                     // Read-modify-write finishes in this cycle.
                     reg_waddr_d = reg_addr;
                     reg_wdata_d = modified;
                     reg_we_d = 1'b1;
                  end
                  test_skip_if_zero_op: begin
                     if (!tested_bit) begin
                        // Fetched word is dropped; a no-operation cycle follows.
                        flush_d = 1'b1;
                        busy_d = 1'b1;
                        state_d = st_flush;
                     end
                  end
                  and_immediate_op: begin
                     // Only the zero flag changes among status bits.
                     working_register_d = and_result;
                     zero_flag_d = (and_result == 8'h00);
                  end
                  call_op: begin
                     // Push return address into the slot the pointer names.
                     stack_d[sp_q] = pc_q + PC_WIDTH'(1);
                     stack_top_d = pc_q + PC_WIDTH'(1);
                     stack_we_d = 1'b1;
                     sp_d = sp_q + SP_WIDTH'(1);
                     pc_d = {pc_high_buffer_q, imm_data};
                     flush_d = 1'b1;
                     busy_d = 1'b1;
                     state_d = st_flush;
                  end
                  pch_write_op: begin
                     // Software loads the high buffer with its low three bits.
                     pc_high_buffer_d = imm_data[2:0];
                  end
                  default: begin
                  end
               endcase
            end
         end
         st_flush: begin
            // Second cycle executes a no-operation in place of the fetched word.
            pc_d = pc_q + PC_WIDTH'(1);
            state_d = st_exec;
         end
         default: begin
            state_d = st_exec;
         end
      endcase
   end

   // Registers only.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_waddr_q <= `REG_WADDR_RESET;
         reg_wdata_q <= `REG_WDATA_RESET;
         reg_we_q <= 1'b0;
         working_register_q <= `WREG_RESET;
         zero_flag_q <= `ZERO_FLAG_RESET;
         pc_q <= `PC_RESET;
         sp_q <= `SP_RESET;
         stack_top_q <= `PC_RESET;
         stack_we_q <= 1'b0;
         pc_high_buffer_q <= `PCHB_RESET;
         flush_q <= 1'b0;
         busy_q <= 1'b0;
         state_q <= st_exec;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_q[i] <= `PC_RESET;
         end
      end else begin
         reg_waddr_q <= reg_waddr_d;
         reg_wdata_q <= reg_wdata_d;
         reg_we_q <= reg_we_d;
         working_register_q <= working_register_d;
         zero_flag_q <= zero_flag_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         stack_top_q <= stack_top_d;
         stack_we_q <= stack_we_d;
         pc_high_buffer_q <= pc_high_buffer_d;
         flush_q <= flush_d;
         busy_q <= busy_d;
         state_q <= state_d;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_q[i] <= stack_d[i];
         end
      end
   end

   // Bit clear writes back the read byte with the selected bit low.
   bit_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == bit_clear_op |=>
      reg_we_q && reg_wdata_q == ($past(reg_rdata) & ~(8'h01 << $past(bit_pos))))
      else $error("bit clear wrong");
   bit_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == bit_set_op |=>
      reg_we_q && reg_wdata_q == ($past(reg_rdata) | (8'h01 << $past(bit_pos))))
      else $error("bit set wrong");
   reg_addr_pass_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == bit_set_op |=>
      reg_waddr_q == $past(reg_addr))
      else $error("register address not passed");
   and_imm_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == and_immediate_op |=>
      working_register_q == ($past(working_register_q) & $past(imm_data)) &&
      zero_flag_q == (working_register_q == 8'h00))
      else $error("and immediate wrong");
   skip_taken_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == test_skip_if_zero_op |=>
      flush_q == !$past(tested_bit))
      else $error("skip decision wrong");
   skip_length_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == test_skip_if_zero_op && !tested_bit
      |=> busy_q ##1 !busy_q && state_q == st_exec)
      else $error("skip not two cycles");
   call_push_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == call_op |=>
      stack_we_q && stack_top_q == $past(pc_q) + 11'h001 &&
      sp_q == $past(sp_q) + 3'h1)
      else $error("call push wrong");
   // The pushed address must land in the slot the pointer named before the call.
   stack_slot_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == call_op |=>
      stack_q[$past(sp_q)] == $past(pc_q) + 11'h001)
      else $error("return slot wrong");
   call_target_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == call_op |=>
      pc_q == {$past(pc_high_buffer_q), $past(imm_data)})
      else $error("call target wrong");
   call_cycles_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      instr_valid && state_q == st_exec && op == call_op |=>
      flush_q && state_q == st_flush ##1 state_q == st_exec)
      else $error("call not two cycles");
endmodule // bit_logic_call_exec

// file: test/bit_logic_call_exec_bench.sv
// Self-checking bench for the bit, logic and call execute block.
`timescale 1ns/1ps
module bit_logic_call_exec_bench
   import bit_logic_pkg::*;
;
   logic sys_clk = 1'b0; // Core clock, 5 ns period.
   logic nrst = 1'b0; // Active-low reset.
   logic instr_valid = 1'b0;
   logic [2:0] op_code = 3'h0;
   logic [5:0] reg_addr = 6'h00;
   logic [2:0] bit_pos = 3'h0;
   logic [7:0] imm_data = 8'h00;
   logic [7:0] reg_rdata = 8'h00;
   logic [5:0] reg_waddr_q;
   logic [7:0] reg_wdata_q, working_register_q;
   logic reg_we_q, zero_flag_q, stack_we_q, flush_q, busy_q;
   logic [10:0] pc_q, stack_top_q;
   logic [2:0] sp_q, pc_high_buffer_q;
   int err_total = 0; // Mismatches seen.
   int n_checks = 0; // Comparisons made.
   logic [7:0] exp_w; // Expected write-back byte.

   // The clock toggles every half period.
   always #2.5 sys_clk = ~sys_clk;

   bit_logic_call_exec i_bit_logic_call_exec (.sys_clk(sys_clk), .nrst(nrst),
      .instr_valid(instr_valid), .op_code(op_code), .reg_addr(reg_addr), .bit_pos(bit_pos),
      .imm_data(imm_data), .reg_rdata(reg_rdata), .reg_waddr_q(reg_waddr_q),
      .reg_wdata_q(reg_wdata_q), .reg_we_q(reg_we_q), .working_register_q(working_register_q),
      .zero_flag_q(zero_flag_q), .pc_q(pc_q), .sp_q(sp_q), .stack_top_q(stack_top_q),
      .stack_we_q(stack_we_q), .pc_high_buffer_q(pc_high_buffer_q), .flush_q(flush_q),
      .busy_q(busy_q));

   // Compares one value and counts the outcome.
   task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // Presents one instruction after an edge, then lets the next edge land.
   // Unless hold is set, valid drops at the taking edge so the word runs once;
   // with hold the word stays up into the dead cycle, where it must be refused.
   task automatic drive(input op_e op, input logic [5:0] a, input logic [2:0] b,
                        input logic [7:0] i, input logic [7:0] r, input bit hold);
      @(posedge sys_clk);
      instr_valid <= (op != op_none);
      op_code <= op;
      reg_addr <= a;
      bit_pos <= b;
      imm_data <= i;
      reg_rdata <= r;
      @(posedge sys_clk);
      if (!hold) begin
         instr_valid <= 1'b0;
      end
      #1;
   endtask

   // Bit clear and set at the operand boundaries, one cycle each.
   task automatic bit_ops_test();
      logic [5:0] a[4] = '{6'h00, 6'h3F, 6'h15, 6'h2A};
      logic [2:0] b[4] = '{3'h0, 3'h7, 3'h3, 3'h5};
      logic [7:0] r[4] = '{8'hFF, 8'h00, 8'h5A, 8'hA5};
      for (int k = 0; k < 4; k++) begin
         exp_w = k[0] ? (r[k] | (8'h01 << b[k])) : (r[k] & ~(8'h01 << b[k]));
         drive(k[0] ? bit_set_op : bit_clear_op, a[k], b[k], 8'h00, r[k], 1'b0);
         check(reg_we_q, 1'b1, "write strobe");
         check(reg_waddr_q, a[k], "write address");
         check(reg_wdata_q, exp_w, "write data");
         check(busy_q, 1'b0, "single cycle");
      end
   endtask

   // Immediate AND with a zero working register sets the zero flag.
   task automatic and_test();
      drive(and_immediate_op, 6'h00, 3'h0, 8'hAF, 8'hFF, 1'b0);
      check(working_register_q, 8'h00, "and result");
      check(zero_flag_q, 1'b1, "zero flag");
      check(reg_we_q, 1'b0, "no register write");
   endtask

   // Bit test skips only on a zero bit, adding one flush cycle.
   task automatic skip_test();
      drive(test_skip_if_zero_op, 6'h05, 3'h2, 8'h00, 8'h5A, 1'b1);
      check(flush_q, 1'b1, "skip flush");
      check(busy_q, 1'b1, "skip second cycle");
      drive(op_none, 6'h00, 3'h0, 8'h00, 8'h00, 1'b0);
      check(flush_q, 1'b0, "flush is one cycle");
      drive(test_skip_if_zero_op, 6'h05, 3'h3, 8'h00, 8'h5A, 1'b0);
      check(flush_q, 1'b0, "no skip on one");
      check(busy_q, 1'b0, "no second cycle");
   endtask

   // Buffer write, then two calls with a refused word in the dead cycle.
   task automatic call_test();
      drive(pch_write_op, 6'h00, 3'h0, 8'h02, 8'h00, 1'b0);
      check(pc_high_buffer_q, 3'h2, "high buffer");
      drive(call_op, 6'h00, 3'h0, 8'h34, 8'h00, 1'b1);
      check(pc_q, 11'h234, "call target");
      // Eight words and one skipped slot ran before the call, so it sat at address 9.
      check(stack_top_q, 11'h00A, "first return address");
      check(sp_q, 3'h1, "pointer after push");
      check({stack_we_q, flush_q, busy_q}, 3'h7, "call pulses");
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      op_code <= call_op;
      imm_data <= 8'h10;
      reg_rdata <= 8'h00;
      #1;
      check({reg_we_q, flush_q, busy_q}, 3'h0, "dead cycle");
      check(pc_q, 11'h235, "dead cycle counter");
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
      check(pc_q, 11'h210, "second target");
      check(stack_top_q, 11'h236, "return address");
      check(sp_q, 3'h2, "pointer increments");
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence: reset, then each scenario in turn.
   initial begin
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      #1;
      check(pc_q, 11'h000, "reset counter");
      check(sp_q, 3'h0, "reset pointer");
      check(working_register_q, 8'h00, "reset working register");
      check({reg_we_q, stack_we_q, flush_q, busy_q}, 4'h0, "reset pulses");
      bit_ops_test();
      and_test();
      skip_test();
      call_test();
      tally_and_finish();
   end
endmodule // bit_logic_call_exec_bench
